// ===== kps_pkg.sv
// Shared constants and types of the keyboard-printer serial control unit.
// Assumes a single 40 MHz APB clock that also stands in for the crystal reference.
package kps_pkg;

   // ****************************************************************
   // Register map (byte addresses, one aligned 32-bit word each)
   // ****************************************************************
   localparam logic [11:0] KPS_CTRL_ADDR = 12'h000;
   localparam logic [11:0] KPS_TXDATA_ADDR = 12'h004;
   localparam logic [11:0] KPS_RXDATA_ADDR = 12'h008;
   localparam logic [11:0] KPS_STATUS_ADDR = 12'h00C;

   // Control word fields: channel in the low bits, then clear/set pairs.
   localparam int KPS_PIA_LSB = 0;
   localparam int KPS_IN_BUSY_CLR = 4;
   localparam int KPS_IN_BUSY_SET = 5;
   localparam int KPS_IN_FLAG_CLR = 6;
   localparam int KPS_IN_FLAG_SET = 7;
   localparam int KPS_OUT_BUSY_CLR = 8;
   localparam int KPS_OUT_BUSY_SET = 9;
   localparam int KPS_OUT_FLAG_CLR = 10;
   localparam int KPS_OUT_FLAG_SET = 11;
   // Status word fields above the packed control bits.
   localparam int KPS_ST_RX_ACTIVE = 7;
   localparam int KPS_ST_TX_ACTIVE = 8;
   localparam int KPS_ST_TX_DONE = 9;
   localparam int KPS_ST_RX_DONE = 10;

   // ****************************************************************
   // Line timing
   // ****************************************************************
   localparam int KPS_CLK_PERIOD_NS = 25;
   localparam int KPS_BIT_RATE_BPS = 110;
   localparam int KPS_CHAR_UNITS = 11;
   localparam int KPS_CHAR_TIME_MS = 100;
   localparam int KPS_TX_OVERSAMPLE = 2;
   localparam int KPS_RX_OVERSAMPLE = 8;
   localparam int KPS_RX_TICK_CYCLES =
      1_000_000_000 / (KPS_CLK_PERIOD_NS * KPS_BIT_RATE_BPS * KPS_RX_OVERSAMPLE);
   localparam logic [1:0] KPS_TX_PER_RX = 2'(KPS_RX_OVERSAMPLE / KPS_TX_OVERSAMPLE - 1);
   localparam logic [2:0] KPS_STOP_FULL = 3'h4;
   localparam logic [2:0] KPS_STOP_LOAD = 3'h1;
   localparam logic [2:0] KPS_RX_SHIFT_CNT = 3'h3;
   localparam logic [7:0] KPS_TX_LAST_PAT = 8'h80;
   localparam logic [7:0] KPS_RX_PRESET = 8'hFF;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic out_flag;
      logic out_busy;
      logic in_flag;
      logic in_busy;
      logic [2:0] interrupt_channel_assignment;
   } kps_ctl_t;

   localparam kps_ctl_t KPS_CTL_RESET = '0;

   typedef enum logic {KPS_TX_IDLE = 1'b0, KPS_TX_ACTIVE = 1'b1} kps_tx_st_t;
   typedef enum logic {KPS_RX_IDLE = 1'b0, KPS_RX_ACTIVE = 1'b1} kps_rx_st_t;

endpackage

// ===== kps_ctrl.sv
// Keyboard-printer serial control unit: APB registers, transmitter, receiver, interrupt request.
// Assumes an APB master on pclk and an asynchronous keyboard line on rx_line.
`timescale 1ns/100ps

module kps_ctrl
   import kps_pkg::*;
#(
   parameter int RX_DIV = KPS_RX_TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_line,
   output logic tx_line,
   output logic [7:0] pi_req
);

   localparam int DIVW = $clog2(RX_DIV + 1);
   localparam logic [DIVW-1:0] DIV_LAST = DIVW'(RX_DIV - 1);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Bus bit 0 is the first character bit; the shifter sends its top bit first.
   function automatic logic [7:0] load_order(input logic [7:0] d);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 7; i++) begin
         r[7-i] = d[i];
      end
      r[0] = 1'b1;
      return r;
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
      return a == reg_addr;
   endfunction

   kps_ctl_t ctl_r;
   kps_tx_st_t tx_st_r;
   kps_rx_st_t rx_st_r;
   logic [DIVW-1:0] pre_r;
   logic [1:0] txdiv_r;
   logic [2:0] stop_cnt_r, div8_r;
   logic [7:0] tbuf_r, rbuf_r, pi_req_r;
   logic [31:0] prdata_r;
   logic rx_tick, tx_tick, div2_r, enable_r, tx_line_r, tx_done_r, pslverr_r;
   logic rx_s1_r, rx_s2_r, rx_s3_r, rx_lvl_r, last_r, rx_done_r;

   // ****************************************************************
   // APB slave
   // ****************************************************************
   logic setup, wr_acc, rd_acc, ctl_wr, dout_wr, din_rd, mapped;
   logic [31:0] status_word;

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign ctl_wr = wr_acc && hit(paddr, KPS_CTRL_ADDR);
   assign dout_wr = wr_acc && hit(paddr, KPS_TXDATA_ADDR);
   assign din_rd = rd_acc && hit(paddr, KPS_RXDATA_ADDR);
   assign mapped = hit(paddr, KPS_CTRL_ADDR) || hit(paddr, KPS_TXDATA_ADDR) ||
                   hit(paddr, KPS_RXDATA_ADDR) || hit(paddr, KPS_STATUS_ADDR);

   always_comb begin
      status_word = '0;
      status_word[6:0] = ctl_r;
      status_word[KPS_ST_RX_ACTIVE] = rx_st_r == KPS_RX_ACTIVE;
      status_word[KPS_ST_TX_ACTIVE] = tx_st_r == KPS_TX_ACTIVE;
      status_word[KPS_ST_TX_DONE] = tx_done_r;
      status_word[KPS_ST_RX_DONE] = rx_done_r;
   end

   // Read data is captured in the setup cycle so the access phase needs no wait state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         pslverr_r <= !mapped;
         if (!pwrite && hit(paddr, KPS_RXDATA_ADDR)) begin
            prdata_r <= {24'h00_0000, rbuf_r};
         end else if (!pwrite && mapped && !hit(paddr, KPS_TXDATA_ADDR)) begin
            prdata_r <= status_word;
         end else begin
            prdata_r <= '0;
         end
      end
   end

   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign pready = 1'b1;

   // ****************************************************************
   // Reference count-up divider chain
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= '0;
         txdiv_r <= '0;
      end else if (pre_r == DIV_LAST) begin
         pre_r <= '0;
         txdiv_r <= txdiv_r + 2'd1;
      end else begin
         pre_r <= pre_r + DIVW'(1);
      end
   end

   // The receive tick runs four times faster than the transmit tick.
   assign rx_tick = pre_r == DIV_LAST;
   assign tx_tick = rx_tick && txdiv_r == KPS_TX_PER_RX;

   // ****************************************************************
   // Transmitter
   // ****************************************************************
   logic dout_ok, tx_start, tx_shift, tx_end;

   // A data word arriving mid-character is refused so the frame in flight is not torn.
   assign dout_ok = dout_wr && tx_st_r == KPS_TX_IDLE;
   assign tx_start = tx_tick && tx_st_r == KPS_TX_IDLE && stop_cnt_r == KPS_STOP_FULL && enable_r;
   assign tx_shift = tx_tick && tx_st_r == KPS_TX_ACTIVE && div2_r;
   assign tx_end = tx_shift && tbuf_r == KPS_TX_LAST_PAT;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_r <= KPS_TX_IDLE;
         div2_r <= 1'b0;
         tx_line_r <= 1'b1;
      end else if (tx_start) begin
         tx_st_r <= KPS_TX_ACTIVE;
         div2_r <= 1'b0;
         tx_line_r <= 1'b0;
      end else if (tx_end) begin
         tx_st_r <= KPS_TX_IDLE;
         div2_r <= 1'b0;
         tx_line_r <= 1'b1;
      end else if (tx_tick && tx_st_r == KPS_TX_ACTIVE) begin
         div2_r <= !div2_r;
         if (tx_shift) begin
            tx_line_r <= tbuf_r[7];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tbuf_r <= '0;
         enable_r <= 1'b0;
      end else if (dout_ok) begin
         tbuf_r <= load_order(pwdata[7:0]);
         enable_r <= 1'b1;
      end else if (tx_end) begin
         tbuf_r <= '0;
      end else if (tx_shift) begin
         tbuf_r <= {tbuf_r[6:0], enable_r};
         enable_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_cnt_r <= KPS_STOP_FULL;
      end else if (tx_end) begin
         stop_cnt_r <= KPS_STOP_LOAD;
      end else if (tx_tick && stop_cnt_r != KPS_STOP_FULL) begin
         stop_cnt_r <= stop_cnt_r + 3'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_done_r <= 1'b0;
      end else if (tx_end) begin
         tx_done_r <= 1'b1;
      end else if (dout_ok) begin
         tx_done_r <= 1'b0;
      end
   end

   assign tx_line = tx_line_r;

   // ****************************************************************
   // Receiver
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
         rx_s3_r <= 1'b1;
         rx_lvl_r <= 1'b1;
      end else begin
         rx_s1_r <= rx_line;
         rx_s2_r <= rx_s1_r;
         rx_s3_r <= rx_s2_r;
         if (rx_s2_r == rx_s3_r) begin
            rx_lvl_r <= rx_s3_r;
         end
      end
   end

   logic rx_start, rx_cnt4, rx_shift, rx_abort, rx_fin, rx_stop;

   assign rx_start = rx_tick && rx_st_r == KPS_RX_IDLE && !rx_lvl_r;
   assign rx_cnt4 = rx_tick && rx_st_r == KPS_RX_ACTIVE && div8_r == KPS_RX_SHIFT_CNT;
   assign rx_shift = rx_cnt4 && !last_r;
   // A buffer still all ones marks the first shift; mark there means noise.
   assign rx_abort = rx_shift && rbuf_r == KPS_RX_PRESET && rx_lvl_r;
   assign rx_fin = rx_shift && !rbuf_r[0];
   assign rx_stop = rx_cnt4 && last_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_r <= KPS_RX_IDLE;
         div8_r <= '0;
         last_r <= 1'b0;
      end else if (rx_start) begin
         rx_st_r <= KPS_RX_ACTIVE;
         div8_r <= '0;
         last_r <= 1'b0;
      end else if (rx_abort || rx_stop) begin
         rx_st_r <= KPS_RX_IDLE;
         div8_r <= '0;
      end else if (rx_tick && rx_st_r == KPS_RX_ACTIVE) begin
         div8_r <= div8_r + 3'd1;
         if (rx_fin) begin
            last_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rbuf_r <= '0;
      end else if (rx_start) begin
         rbuf_r <= KPS_RX_PRESET;
      end else if (rx_shift) begin
         rbuf_r <= {rx_lvl_r, rbuf_r[7:1]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_done_r <= 1'b0;
      end else if (rx_fin) begin
         rx_done_r <= 1'b1;
      end else if (din_rd || (rx_shift && rbuf_r == KPS_RX_PRESET)) begin
         rx_done_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Control bits and interrupt request
   // ****************************************************************
   // Hardware events win over software clears landing in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r <= KPS_CTL_RESET;
      end else begin
         if (ctl_wr) begin
            ctl_r.interrupt_channel_assignment <= pwdata[KPS_PIA_LSB +: 3];
         end
         if (dout_wr) begin
            ctl_r.out_busy <= 1'b1;
         end else if (tx_end) begin
            ctl_r.out_busy <= 1'b0;
         end else if (ctl_wr && pwdata[KPS_OUT_BUSY_SET]) begin
            ctl_r.out_busy <= 1'b1;
         end else if (ctl_wr && pwdata[KPS_OUT_BUSY_CLR]) begin
            ctl_r.out_busy <= 1'b0;
         end
         if (tx_end || (ctl_wr && pwdata[KPS_OUT_FLAG_SET])) begin
            ctl_r.out_flag <= 1'b1;
         end else if (dout_wr || (ctl_wr && pwdata[KPS_OUT_FLAG_CLR])) begin
            ctl_r.out_flag <= 1'b0;
         end
         if (rx_start || (ctl_wr && pwdata[KPS_IN_BUSY_SET])) begin
            ctl_r.in_busy <= 1'b1;
         end else if (rx_fin || (ctl_wr && pwdata[KPS_IN_BUSY_CLR])) begin
            ctl_r.in_busy <= 1'b0;
         end
         if (rx_fin || (ctl_wr && pwdata[KPS_IN_FLAG_SET])) begin
            ctl_r.in_flag <= 1'b1;
         end else if (din_rd || (ctl_wr && pwdata[KPS_IN_FLAG_CLR])) begin
            ctl_r.in_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pi_req_r <= '0;
      end else begin
         pi_req_r <= '0;
         if ((ctl_r.in_flag || ctl_r.out_flag) && ctl_r.interrupt_channel_assignment != 3'd0) begin
            pi_req_r[ctl_r.interrupt_channel_assignment] <= 1'b1;
         end
      end
   end

   assign pi_req = pi_req_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   // A transmit end in the same cycle sets the flag on purpose, so it is left out here.
   dout_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
      dout_wr && !tx_end |=> ctl_r.out_busy && !ctl_r.out_flag)
      else $error("Data-out did not set output busy and clear output flag.");
   irq_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctl_r.in_flag || ctl_r.out_flag) && ctl_r.interrupt_channel_assignment != 3'd0 |=> pi_req[$past(ctl_r.interrupt_channel_assignment)] && $onehot(pi_req))
      else $error("Interrupt request not raised on the assigned channel.");
   tx_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(tx_st_r) |-> $past(stop_cnt_r) == 3'h4 && $past(enable_r) && !tx_line)
      else $error("Transmission started without full stop count or pending enable.");
   tx_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(tx_st_r) |-> tx_line && stop_cnt_r == 3'h1 && tx_done_r && tbuf_r == 8'h00)
      else $error("Leaving transmit did not load stop counter, set done and mark.");
   tx_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      dout_ok |=> tbuf_r[0] && tbuf_r[7] == $past(pwdata[0]) && enable_r && !tx_done_r)
      else $error("Transmit buffer load order or eighth bit wrong.");
   rx_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(rx_st_r) |-> ctl_r.in_busy && rbuf_r == 8'hFF && div8_r == 3'h0 && !last_r)
      else $error("Receiver activation did not preset buffer and set input busy.");
   rx_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      rx_fin |=> rx_done_r && ctl_r.in_flag && last_r)
      else $error("Final receive shift did not set done, flag and last unit.");
   rx_noise_a: assert property (@(posedge pclk) disable iff (!presetn)
      rx_abort |=> rx_st_r == KPS_RX_IDLE)
      else $error("Noise at first shift did not abandon reception.");
   din_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      din_rd && !rx_fin |=> !rx_done_r && !ctl_r.in_flag)
      else $error("Data-in did not clear input flag and receive done.");

endmodule

// ===== kps_line_model.sv
// Behavioural keyboard-printer: a keyboard that sends framed characters and a printer that decodes them.
// Assumes pclk as time base and BIT_CYC pclk cycles for one serial unit.
`timescale 1ns/100ps
module kps_line_model
   import kps_pkg::*;
#(
   parameter int BIT_CYC = 32
) (
   input wire logic pclk,
   output logic rx_line,
   input wire logic tx_line
);
   logic [7:0] last_char;
   logic frame_ok;
   int n_chars;
   int period;
   realtime t_fall;

   // ****************************************************************
   // Keyboard side
   // ****************************************************************
   // Start space, eight data bits first bit first, two mark stop units.
   task automatic send_key(input logic [7:0] ch);
      logic [10:0] fr;
      fr = {2'b11, ch, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rx_line <= fr[i];
         repeat (BIT_CYC) @(posedge pclk);
      end
   endtask

   // A short space that is too brief to be a start unit.
   task automatic noise(input int n);
      rx_line <= 1'b0;
      repeat (n) @(posedge pclk);
      rx_line <= 1'b1;
   endtask

   // ****************************************************************
   // Printer side
   // ****************************************************************
   // Samples each unit at its middle; the stop must show two mark units.
   initial begin
      rx_line = 1'b1;
      frame_ok = 1'b1;
      n_chars = 0;
      period = 0;
      t_fall = 0;
      forever begin
         @(negedge tx_line);
         if (n_chars > 0) begin
            period = int'(($realtime - t_fall) / KPS_CLK_PERIOD_NS);
         end
         t_fall = $realtime;
         repeat (BIT_CYC / 2) @(posedge pclk);
         if (tx_line !== 1'b0) frame_ok = 1'b0;
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge pclk);
            last_char[i] = tx_line;
         end
         n_chars++;
         repeat (2) begin
            repeat (BIT_CYC) @(posedge pclk);
            if (tx_line !== 1'b1) frame_ok = 1'b0;
         end
      end
   end
endmodule

// ===== kps_ctrl_bench.sv
// Self-checking bench of the keyboard-printer serial control unit.
// Assumes the design answers APB with pready and the serial side is the line model.
`timescale 1ns/100ps
module kps_ctrl_bench
   import kps_pkg::*;
();
   localparam int RXD = 4;
   localparam int BITC = RXD * KPS_RX_OVERSAMPLE;
   logic pclk = 1'b0;
   logic presetn;
   logic psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rq;
   logic pready, pslverr, re, rx_line, tx_line;
   logic [7:0] pi_req;
   int fails = 0;
   int n_compared = 0;

   always #12.5 pclk = ~pclk;

   kps_ctrl #(.RX_DIV(RXD)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line), .pi_req(pi_req));
   kps_line_model #(.BIT_CYC(BITC)) kbd (.pclk(pclk), .rx_line(rx_line), .tx_line(tx_line));

   // ****************************************************************
   // Bus and compare helpers
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One idle edge follows every transfer, so no signal is driven twice in one step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Polls status until the output flag (bit 6) reads set; only the watchdog ends a hang.
   task automatic wait_flag();
      apb(1'b0, KPS_STATUS_ADDR, '0);
      while (rq[6] !== 1'b1) begin
         apb(1'b0, KPS_STATUS_ADDR, '0);
      end
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_ctrl();
      chk("idle line", 32'h0000_0001, {31'h0, tx_line});
      apb(1'b0, 12'h010, '0);
      chk("unmapped err", 32'h0000_0001, {31'h0, re});
      apb(1'b1, KPS_CTRL_ADDR, 32'h0000_02A3);
      apb(1'b0, KPS_STATUS_ADDR, '0);
      chk("ctrl set", 32'h0000_003B, rq & 32'h0000_007F);
      chk("irq ch3", 32'h0000_0008, {24'h0, pi_req});
      apb(1'b1, KPS_CTRL_ADDR, 32'h0000_0005);
      apb(1'b0, KPS_STATUS_ADDR, '0);
      chk("pia only", 32'h0000_003D, rq & 32'h0000_007F);
      apb(1'b1, KPS_CTRL_ADDR, 32'h0000_0155);
      apb(1'b0, KPS_STATUS_ADDR, '0);
      chk("ctrl clr", 32'h0000_0005, rq & 32'h0000_007F);
      chk("no irq", 32'h0000_0000, {24'h0, pi_req});
      apb(1'b1, KPS_CTRL_ADDR, 32'h0000_0AA1);
      apb(1'b0, KPS_STATUS_ADDR, '0);
      chk("ctrl all set", 32'h0000_0079, rq & 32'h0000_007F);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, KPS_STATUS_ADDR, '0);
      chk("bus reset", 32'h0000_0000, rq & 32'h0000_007F);
      $display("control test done");
   endtask

   task automatic t_rx();
      apb(1'b1, KPS_CTRL_ADDR, 32'h0000_0002);
      fork
         kbd.send_key(8'hDA);
         begin
            repeat (120) @(posedge pclk);
            apb(1'b0, KPS_STATUS_ADDR, '0);
            chk("in busy", 32'h0000_0088, rq & 32'h0000_0098);
         end
      join
      apb(1'b0, KPS_STATUS_ADDR, '0);
      chk("rx done", 32'h0000_0412, rq & 32'h0000_04FF);
      chk("irq ch2", 32'h0000_0004, {24'h0, pi_req});
      apb(1'b0, KPS_RXDATA_ADDR, '0);
      chk("rx char", 32'h0000_00DA, rq & 32'h0000_00FF);
      apb(1'b0, KPS_STATUS_ADDR, '0);
      chk("rx read clr", 32'h0000_0000, rq & 32'h0000_0410);
      kbd.send_key(8'hC1);
      apb(1'b1, KPS_CTRL_ADDR, 32'h0000_0000);
      // The request register follows the channel one edge later.
      @(posedge pclk);
      chk("pia zero", 32'h0000_0000, {24'h0, pi_req});
      apb(1'b1, KPS_CTRL_ADDR, 32'h0000_0042);
      apb(1'b0, KPS_STATUS_ADDR, '0);
      chk("restore", 32'h0000_0002, rq & 32'h0000_0017);
      kbd.noise(8);
      repeat (100) @(posedge pclk);
      apb(1'b0, KPS_STATUS_ADDR, '0);
      chk("noise", 32'h0000_0000, rq & 32'h0000_0090);
      $display("receive test done");
   endtask

   task automatic t_tx();
      apb(1'b1, KPS_CTRL_ADDR, 32'h0000_0403);
      apb(1'b1, KPS_TXDATA_ADDR, 32'h0000_00FF);
      apb(1'b0, KPS_STATUS_ADDR, '0);
      chk("tx start", 32'h0000_0020, rq & 32'h0000_0260);
      wait_flag();
      chk("tx done", 32'h0000_0240, rq & 32'h0000_0260);
      chk("irq ch3", 32'h0000_0008, {24'h0, pi_req});
      chk("rubout", 32'h0000_00FF, {24'h0, kbd.last_char});
      apb(1'b1, KPS_TXDATA_ADDR, 32'h0000_0041);
      wait_flag();
      apb(1'b1, KPS_TXDATA_ADDR, 32'h0000_0042);
      wait_flag();
      chk("char", 32'h0000_00C2, {24'h0, kbd.last_char});
      chk("period", 32'(KPS_CHAR_UNITS * BITC), 32'(kbd.period));
      chk("frame", 32'h0000_0001, {31'h0, kbd.frame_ok});
      chk("count", 32'h0000_0003, 32'(kbd.n_chars));
      $display("transmit test done");
   endtask

   // ****************************************************************
   // Sequence and verdict
   // ****************************************************************
   task automatic complete_run();
      $display("compares %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (16) @(posedge pclk);
      chk("reset irq", 32'h0000_0000, {24'h0, pi_req});
      presetn <= 1'b1;
      @(posedge pclk);
      t_ctrl();
      t_rx();
      t_tx();
      complete_run();
   end

   // A hang is cut well beyond the few thousand cycles the scenarios need.
   initial begin
      repeat (30000) @(posedge pclk);
      fails++;
      $display("[ERR] watchdog expected end seen hang");
      complete_run();
   end
endmodule
